// ==== hdl/sci_pkg.sv ====
// constants and types for the serial channel core
package sci_pkg;
    localparam int ADDR_W = 8;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FMT = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_CTL = 8'h08;
    localparam logic [7:0] OFS_TXD = 8'h0c;
    localparam logic [7:0] OFS_STS = 8'h10;
    localparam logic [7:0] OFS_RXD = 8'h14;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FMT_SYNC  = 7;
    localparam int FMT_CHR7  = 6;
    localparam int FMT_PAR   = 5;
    localparam int FMT_ODD   = 4;
    localparam int FMT_STOP2 = 3;
    localparam int FMT_MP    = 2;
    localparam int FMT_CKS   = 0;
    localparam int CTL_TXEN  = 0;
    localparam int CTL_RXEN  = 1;
    localparam int CTL_MSB   = 2;
    localparam int CTL_EXT   = 3;
    localparam int CTL_TIE   = 4;
    localparam int CTL_TEIE  = 5;
    localparam int CTL_RIE   = 6;
    localparam int CTL_EIE   = 7;
    localparam int CTL_MPBT  = 8;
    localparam int STS_TX_BUFFER_EMPTY_FLAG  = 7;
    localparam int STS_RX_BUFFER_FULL_FLAG  = 6;
    localparam int STS_ORER  = 5;
    localparam int STS_FER   = 4;
    localparam int STS_PER   = 3;
    localparam int STS_TEND  = 2;
    localparam int STS_MPB   = 0;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RXD = 8'h00;
    localparam logic [7:0] RST_TXD = 8'hff;
    localparam logic [7:0] RST_FMT = 8'h00;
    localparam logic [7:0] RST_DIV = 8'hff;
    localparam logic [8:0] RST_CTL = 9'h000;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {TX_IDLE, TX_BUSY} tx_state_e;
    typedef enum logic [0:0] {RX_IDLE, RX_BUSY} rx_state_e;
endpackage

// ==== hdl/serial_comm_interface_core.sv ====
// serial channel core: async and clocked sync, axi4-lite registers
// Function
// - complete received frame moves to rx data buffer automatically
// - rx shifter accepts next frame right after that transfer
// - rx buffer is 8 bits, resets to zero, ignores writes
// - tx buffer is 8 bits, resets to all ones, always read/write
// - empty tx shifter loads tx buffer and starts sending
// - waiting data loads at frame end with no gap
// - tx shifter drives txd pin, not reachable by software
// - format bit 7 selects async (0) or clocked sync (1)
// - async bit 6 selects 8 or 7 data bits, 7 lsb first
// - clocked sync always uses 8 data bits
// - async bit 5 adds parity on send, checks on receive
// - multiprocessor format disables parity generation and checking
// - bit 4 selects even (0) or odd (1) parity
// - async bit 3 selects one or two sent stop bits
// - receiver checks first stop only; low after it starts frame
// - lsb or msb first selectable, 7-bit async always lsb
// - four requests: tx end, tx empty, rx full, rx error
// - async detects parity, overrun, framing; sync overrun only
// - transmitter and receiver run independently, full duplex
// - transfer clock from baud generator or external sck pin
// - format bits 1:0 select clock, clock/4, clock/16, clock/64
// - async bit 2 enables multiprocessor format, parity ignored
`timescale 1ns/100ps
`default_nettype none
module serial_comm_interface_core (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rstn_i,
    input  wire logic [sci_pkg::ADDR_W-1:0] awaddr_i,
    input  wire logic                      awvalid_i,
    output logic                           awready_o,
    input  wire logic [31:0]               wdata_i,
    input  wire logic [3:0]                wstrb_i,
    input  wire logic                      wvalid_i,
    output logic                           wready_o,
    output logic [1:0]                     bresp_o,
    output logic                           bvalid_o,
    input  wire logic                      bready_i,
    input  wire logic [sci_pkg::ADDR_W-1:0] araddr_i,
    input  wire logic                      arvalid_i,
    output logic                           arready_o,
    output logic [31:0]                    rdata_o,
    output logic [1:0]                     rresp_o,
    output logic                           rvalid_o,
    input  wire logic                      rready_i,
    input  wire logic                      rxd_i,
    output logic                           txd_o,
    input  wire logic                      sck_i,
    output logic                           sck_o,
    output logic                           sck_oe_o,
    output logic                           irq_tx_end_o,
    output logic                           irq_tx_empty_o,
    output logic                           irq_rx_full_o,
    output logic                           irq_rx_err_o
);
    import sci_pkg::*;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7-i];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_FMT) || (a == OFS_DIV) || (a == OFS_CTL) ||
                 (a == OFS_TXD) || (a == OFS_STS) || (a == OFS_RXD);
    endfunction

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_meta_q, rst_n;
    logic rxd_m_q, rxd_s_q, rxd_p_q, sck_m_q, sck_s_q, sck_p_q;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            rst_meta_q <= 1'h0;
            rst_n      <= 1'h0;
        end
        else
        begin
            rst_meta_q <= 1'h1;
            rst_n      <= rst_meta_q;
        end
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            {rxd_m_q, rxd_s_q, rxd_p_q} <= 3'h7;
            {sck_m_q, sck_s_q, sck_p_q} <= 3'h7;
        end
        else
        begin
            {rxd_m_q, rxd_s_q, rxd_p_q} <= {rxd_i, rxd_m_q, rxd_s_q};
            {sck_m_q, sck_s_q, sck_p_q} <= {sck_i, sck_m_q, sck_s_q};
        end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic       aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
    logic       arready_q, rvalid_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic       aw_take, w_take, wr_fire, ar_take, rd_rx;
    logic       aw_have_d, w_have_d, bvalid_d, rvalid_d;
    assign aw_take   = awvalid_i & awready_q;
    assign w_take    = wvalid_i & wready_q;
    assign wr_fire   = aw_have_q & w_have_q & ~bvalid_q;
    assign aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
    assign w_have_d  = (w_have_q | w_take) & ~wr_fire;
    assign bvalid_d  = (bvalid_q & ~bready_i) | wr_fire;
    assign ar_take   = arvalid_i & arready_q;
    assign rvalid_d  = (rvalid_q & ~rready_i) | ar_take;
    assign rd_rx     = ar_take & (araddr_i == OFS_RXD);
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            {aw_have_q, w_have_q, awready_q, wready_q} <= 4'h0;
            {bvalid_q, arready_q, rvalid_q} <= 3'h0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q  <= ~w_have_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            rvalid_q  <= rvalid_d;
            arready_q <= ~rvalid_d;
            if (aw_take)
                waddr_q <= awaddr_i;
            if (w_take)
            begin
                wdata_q <= wdata_i;
                wstrb_q <= wstrb_i;
            end
            if (wr_fire)
                bresp_q <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
    assign awready_o = awready_q;
    assign wready_o  = wready_q;
    assign bvalid_o  = bvalid_q;
    assign bresp_o   = bresp_q;
    assign arready_o = arready_q;
    assign rvalid_o  = rvalid_q;
    assign rdata_o   = rdata_q;
    assign rresp_o   = rresp_q;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] fmt_q, div_q, tx_data_q, rx_data_q;
    logic [8:0] ctl_q;
    logic       wr_lo;
    assign wr_lo = wr_fire & wstrb_q[0];
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            fmt_q <= RST_FMT;
            div_q <= RST_DIV;
            ctl_q <= RST_CTL;
        end
        else
        begin
            if (wr_lo && waddr_q == OFS_FMT)
                fmt_q <= wdata_q[7:0];
            if (wr_lo && waddr_q == OFS_DIV)
                div_q <= wdata_q[7:0];
            if (wr_lo && waddr_q == OFS_CTL)
                ctl_q[7:0] <= wdata_q[7:0];
            if (wr_fire && wstrb_q[1] && waddr_q == OFS_CTL)
                ctl_q[CTL_MPBT] <= wdata_q[CTL_MPBT];
        end
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
            tx_data_q <= RST_TXD;
        else if (wr_lo && waddr_q == OFS_TXD)
            tx_data_q <= wdata_q[7:0];
    logic sync_m, chr7, mp_m, par_m, has_x, msb, ext;
    assign sync_m = fmt_q[FMT_SYNC];
    assign chr7   = ~sync_m & fmt_q[FMT_CHR7];
    assign mp_m   = ~sync_m & fmt_q[FMT_MP];
    assign par_m  = ~sync_m & fmt_q[FMT_PAR] & ~mp_m;
    assign has_x  = mp_m | par_m;
    assign msb    = ctl_q[CTL_MSB] & ~chr7;
    assign ext    = ctl_q[CTL_EXT];

    // ------------------------------------------------------------
    // baud generator and transfer clock
    // ------------------------------------------------------------
    logic [5:0] pre_q, pre_lim;
    logic [7:0] bcnt_q;
    logic       sck_q, itick, run, srise, sfall, atick, tx_act;
    always_comb
        case (fmt_q[FMT_CKS +: 2])
            2'h0:    pre_lim = 6'h00;
            2'h1:    pre_lim = 6'h03;
            2'h2:    pre_lim = 6'h0f;
            default: pre_lim = 6'h3f;
        endcase
    assign itick = (pre_q == pre_lim) && (bcnt_q == 8'h00);
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            pre_q  <= 6'h00;
            bcnt_q <= 8'h00;
        end
        else if (pre_q == pre_lim)
        begin
            pre_q  <= 6'h00;
            bcnt_q <= (bcnt_q == 8'h00) ? div_q : bcnt_q - 8'h01;
        end
        else
            pre_q <= pre_q + 6'h01;
    logic tx_buffer_empty_flag_q;
    assign run = sync_m & ~ext & (tx_act | ctl_q[CTL_RXEN] |
                 (~tx_buffer_empty_flag_q & ctl_q[CTL_TXEN]));
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
            sck_q <= 1'h1;
        else if (!run)
            sck_q <= 1'h1;
        else if (itick)
            sck_q <= ~sck_q;
    // ext selects the pin edges as transfer clock
    assign srise = ext ? (sck_s_q & ~sck_p_q) : (itick & run & ~sck_q);
    assign sfall = ext ? (~sck_s_q & sck_p_q) : (itick & run & sck_q);
    assign atick = ext ? (sck_s_q & ~sck_p_q) : itick;
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            sck_o    <= 1'h1;
            sck_oe_o <= 1'h0;
        end
        else
        begin
            sck_o    <= sck_q;
            sck_oe_o <= sync_m & ~ext;
        end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    tx_state_e   tx_st_q;
    logic [3:0]  tx_os_q, tx_cnt_q, tx_len;
    logic [11:0] tx_sh_q, tx_frame;
    logic [7:0]  td, tw;
    logic        tx_step, tx_load, tx_end, tx_x;
    assign tx_act = (tx_st_q == TX_BUSY);
    assign td = msb ? rev8(tx_data_q) : tx_data_q;
    assign tw = chr7 ? {1'h0, td[6:0]} : td;
    assign tx_x = !has_x ? 1'h1 : mp_m ? ctl_q[CTL_MPBT] :
                  (^tw) ^ fmt_q[FMT_ODD];
    always_comb
    begin
        if (sync_m)
        begin
            tx_frame = {4'hf, td};
            tx_len   = 4'h8;
        end
        else
        begin
            // trailing ones form the stop bits
            tx_frame = chr7 ? {3'h7, tx_x, td[6:0], 1'h0}
                            : {2'h3, tx_x, td, 1'h0};
            tx_len   = 4'h2 + (chr7 ? 4'h7 : 4'h8) + {3'h0, has_x} +
                       {3'h0, fmt_q[FMT_STOP2]};
        end
    end
    assign tx_step = ctl_q[CTL_TXEN] & (sync_m ? sfall :
                     (atick & (tx_os_q == OVS_LAST)));
    assign tx_load = tx_step & (tx_cnt_q == 4'h0) & ~tx_buffer_empty_flag_q;
    assign tx_end  = tx_step & (tx_cnt_q == 4'h0) & tx_buffer_empty_flag_q & tx_act;
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
            tx_os_q <= 4'h0;
        else if (atick)
            tx_os_q <= tx_os_q + 4'h1;
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            tx_st_q  <= TX_IDLE;
            tx_cnt_q <= 4'h0;
            tx_sh_q  <= 12'hfff;
            txd_o    <= 1'h1;
        end
        else if (!ctl_q[CTL_TXEN])
        begin
            tx_st_q  <= TX_IDLE;
            tx_cnt_q <= 4'h0;
            txd_o    <= 1'h1;
        end
        else if (tx_step)
        begin
            if (tx_cnt_q != 4'h0)
            begin
                txd_o    <= tx_sh_q[0];
                tx_sh_q  <= {1'h1, tx_sh_q[11:1]};
                tx_cnt_q <= tx_cnt_q - 4'h1;
            end
            else if (!tx_buffer_empty_flag_q)
            begin
                txd_o    <= tx_frame[0];
                tx_sh_q  <= {1'h1, tx_frame[11:1]};
                tx_cnt_q <= tx_len - 4'h1;
                tx_st_q  <= TX_BUSY;
            end
            else
            begin
                txd_o   <= 1'h1;
                tx_st_q <= TX_IDLE;
            end
        end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    rx_state_e   rx_st_q;
    logic [11:0] rx_sh_q, rx_new, al;
    logic [3:0]  rx_os_q, rx_n_q, rx_len;
    logic [7:0]  rraw, rdat;
    logic        rx_smp, rx_fin, rx_bad, rx_xb, rx_stop;
    assign rx_len = sync_m ? 4'h8 :
                    4'h2 + (chr7 ? 4'h7 : 4'h8) + {3'h0, has_x};
    assign rx_smp = ctl_q[CTL_RXEN] & (sync_m ? srise :
                    (rx_st_q == RX_BUSY) & atick & (rx_os_q == OVS_MID));
    assign rx_new = {rxd_s_q, rx_sh_q[11:1]};
    assign rx_bad = ~sync_m & (rx_n_q == 4'h0) & rxd_s_q;
    assign rx_fin = rx_smp & ~rx_bad & (rx_n_q == rx_len - 4'h1);
    assign al      = rx_new >> (4'hc - rx_len);
    assign rraw    = sync_m ? al[7:0] : chr7 ? {1'h0, al[7:1]} : al[8:1];
    assign rdat    = msb ? rev8(rraw) : rraw;
    assign rx_xb   = chr7 ? al[8] : al[9];
    assign rx_stop = al[rx_len - 4'h1];
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            rx_st_q <= RX_IDLE;
            rx_os_q <= 4'h0;
            rx_n_q  <= 4'h0;
            rx_sh_q <= 12'h000;
        end
        else if (!ctl_q[CTL_RXEN])
        begin
            rx_st_q <= RX_IDLE;
            rx_n_q  <= 4'h0;
        end
        else if (!sync_m && rx_st_q == RX_IDLE)
        begin
            if (rxd_p_q && !rxd_s_q)
            begin
                rx_st_q <= RX_BUSY;
                rx_os_q <= 4'h0;
                rx_n_q  <= 4'h0;
            end
        end
        else
        begin
            if (atick)
                rx_os_q <= rx_os_q + 4'h1;
            if (rx_smp)
            begin
                rx_sh_q <= rx_new;
                rx_n_q  <= rx_fin ? 4'h0 : rx_n_q + 4'h1;
                if (rx_fin || rx_bad)
                    rx_st_q <= RX_IDLE;
            end
        end

    // ------------------------------------------------------------
    // rx buffer, status flags and requests
    // ------------------------------------------------------------
    logic rx_buffer_full_flag_q, orer_q, fer_q, per_q, tend_q, mpb_q, sts_w;
    assign sts_w = wr_lo & (waddr_q == OFS_STS);
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
            rx_data_q <= RST_RXD;
        else if (rx_fin && !rx_buffer_full_flag_q)
            rx_data_q <= rdat;
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            {tx_buffer_empty_flag_q, tend_q} <= 2'h3;
            {rx_buffer_full_flag_q, orer_q, fer_q, per_q, mpb_q} <= 5'h00;
        end
        else
        begin
            if (tx_load)
                tx_buffer_empty_flag_q <= 1'h1;
            else if (wr_lo && waddr_q == OFS_TXD)
                tx_buffer_empty_flag_q <= 1'h0;
            if (tx_end)
                tend_q <= 1'h1;
            else if (wr_lo && waddr_q == OFS_TXD)
                tend_q <= 1'h0;
            if (rx_fin && !rx_buffer_full_flag_q)
                rx_buffer_full_flag_q <= 1'h1;
            else if (rd_rx || (sts_w && wdata_q[STS_RX_BUFFER_FULL_FLAG]))
                rx_buffer_full_flag_q <= 1'h0;
            if (rx_fin && rx_buffer_full_flag_q)
                orer_q <= 1'h1;
            else if (sts_w && wdata_q[STS_ORER])
                orer_q <= 1'h0;
            if (rx_fin && !rx_buffer_full_flag_q && !sync_m && !rx_stop)
                fer_q <= 1'h1;
            else if (sts_w && wdata_q[STS_FER])
                fer_q <= 1'h0;
            if (rx_fin && !rx_buffer_full_flag_q && par_m &&
                ((^rraw) ^ fmt_q[FMT_ODD] ^ rx_xb))
                per_q <= 1'h1;
            else if (sts_w && wdata_q[STS_PER])
                per_q <= 1'h0;
            if (rx_fin && !rx_buffer_full_flag_q && mp_m)
                mpb_q <= rx_xb;
        end
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
            {irq_tx_end_o, irq_tx_empty_o, irq_rx_full_o, irq_rx_err_o}
                <= 4'h0;
        else
        begin
            irq_tx_end_o   <= tend_q & ctl_q[CTL_TEIE];
            irq_tx_empty_o <= tx_buffer_empty_flag_q & ctl_q[CTL_TIE];
            irq_rx_full_o  <= rx_buffer_full_flag_q & ctl_q[CTL_RIE];
            irq_rx_err_o   <= (orer_q | fer_q | per_q) & ctl_q[CTL_EIE];
        end
    always_ff @(posedge ref_clk_i or negedge rst_n)
        if (!rst_n)
        begin
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rresp_q <= mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
            case (araddr_i)
                OFS_FMT: rdata_q <= {24'h0, fmt_q};
                OFS_DIV: rdata_q <= {24'h0, div_q};
                OFS_CTL: rdata_q <= {23'h0, ctl_q};
                OFS_TXD: rdata_q <= {24'h0, tx_data_q};
                OFS_RXD: rdata_q <= {24'h0, rx_data_q};
                OFS_STS: rdata_q <= {24'h0, tx_buffer_empty_flag_q, rx_buffer_full_flag_q, orer_q, fer_q,
                                     per_q, tend_q, 1'h0, mpb_q};
                default: rdata_q <= 32'h0;
            endcase
        end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);
    sequence s_load;
        tx_load ##1 tx_act;
    endsequence
    rx_move_a: assert property (rx_fin && !rx_buffer_full_flag_q |=>
        rx_buffer_full_flag_q && rx_data_q == $past(rdat))
        else $error("received frame not moved to buffer");
    rx_ro_a: assert property (wr_lo && waddr_q == OFS_RXD && !rx_fin
        |=> $stable(rx_data_q))
        else $error("rx buffer changed by a write");
    tx_wr_a: assert property (wr_lo && waddr_q == OFS_TXD |=>
        tx_data_q == $past(wdata_q[7:0]) && !tx_buffer_empty_flag_q)
        else $error("tx buffer write lost");
    tx_load_a: assert property (s_load |-> tx_buffer_empty_flag_q)
        else $error("tx load did not free the buffer");
    tx_start_a: assert property (tx_load && !sync_m |=> !txd_o)
        else $error("async frame did not start low");
    tx_idle_a: assert property (!tx_act |-> txd_o)
        else $error("txd not idle high");
    rx_over_a: assert property (rx_fin && rx_buffer_full_flag_q |=>
        orer_q && $stable(rx_data_q))
        else $error("overrun not flagged");
    sync_err_a: assert property (sync_m && rx_fin |=>
        !$rose(fer_q) && !$rose(per_q))
        else $error("sync mode flagged a format error");
    tx_end_a: assert property (tx_end |=> tend_q && !tx_act)
        else $error("transmit end not flagged");
endmodule
`default_nettype wire

// ==== verification/remote_line_model.sv ====
// remote end: echoes the transmit line back after a short delay
`timescale 1ns/100ps
`default_nettype none
module remote_line_model #(parameter int DLY = 5) (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o = 1'b1);
    logic [DLY-2:0] line_q = '1;
    always @(posedge clk_i) {rxd_o, line_q} <= {line_q, txd_i};
endmodule
`default_nettype wire

// ==== verification/tb_serial_comm_interface_core.sv ====
// bench: register access and looped-back serial frames
`timescale 1ns/100ps
`default_nettype none
module tb_serial_comm_interface_core;
    import sci_pkg::*;
    logic ref_clk_i = '0, rstn_i = '0, awvalid_i = '0, wvalid_i = '0;
    logic bready_i = '0, arvalid_i = '0, rready_i = '0, sck_i = '1;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, rxd_i, txd_o;
    logic sck_o, sck_oe_o, irq_tx_end_o, irq_tx_empty_o;
    logic irq_rx_full_o, irq_rx_err_o;
    logic [ADDR_W-1:0] awaddr_i = '0, araddr_i = '0;
    logic [31:0] wdata_i = '0, rdata_o, seed = 32'd80843, v, d;
    logic [3:0] wstrb_i = 4'hf;
    logic [1:0] bresp_o, rresp_o, r;
    logic [7:0] modes [10] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h24,
                               8'h41, 8'h22, 8'h0b, 8'h01};
    int fail_count = 0, checks_done = 0;
    serial_comm_interface_core serial_comm_interface_core_inst (
        .ref_clk_i, .rstn_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
        .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
        .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
        .rready_i, .rxd_i, .txd_o, .sck_i, .sck_o, .sck_oe_o, .irq_tx_end_o,
        .irq_tx_empty_o, .irq_rx_full_o, .irq_rx_err_o);
    remote_line_model remote_line_model_inst (
        .clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] exp_rx(input logic [7:0] b, m);
        return {24'h0, b[7] & (m[7] | ~m[6]), b[6:0]};
    endfunction
    task chk(input logic [31:0] got, exp);
        checks_done++;
        fail_count += int'(got !== exp);
        if (got !== exp) $display("BAD t=%0t got %h exp %h", $time, got, exp);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge ref_clk_i);
        {awaddr_i, wdata_i, awvalid_i, wvalid_i, bready_i} <= {a, w, 3'h7};
        do @(posedge ref_clk_i) {awvalid_i, wvalid_i} <=
            {awvalid_i & ~awready_o, wvalid_i & ~wready_o};
        while (bvalid_o !== 1'b1);
        r = bresp_o;
        bready_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        {araddr_i, arvalid_i, rready_i} <= {a, 2'h3};
        do @(posedge ref_clk_i); while (arready_o !== 1'b1);
        arvalid_i <= 1'b0;
        do @(posedge ref_clk_i); while (rvalid_o !== 1'b1);
        v = rdata_o;
        rready_i <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) sck_i <= ~sck_i;
    initial
    begin
        #2000000;
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rdc(OFS_TXD, 32'hff);
        wr(OFS_RXD, 32'h5a);
        rdc(OFS_RXD, 32'h0);
        wr(8'h40, 32'h1);
        chk(r, RESP_SLVERR);
        wr(OFS_DIV, 32'h0);
        wr(OFS_CTL, 32'h3);
        foreach (modes[i])
        begin
            wr(OFS_CTL, {28'h0, modes[i] == 8'h41, modes[i][0], 2'h3});
            wr(OFS_FMT, modes[i]);
            d = xs();
            wr(OFS_TXD, d[7:0]);
            do rd(OFS_STS); while (v[STS_TX_BUFFER_EMPTY_FLAG] !== 1'b1);
            wr(OFS_TXD, d[15:8]);
            do rd(OFS_STS); while (v[STS_RX_BUFFER_FULL_FLAG] !== 1'b1);
            rdc(OFS_RXD, exp_rx(d[7:0], modes[i]));
            do rd(OFS_STS); while (v[STS_RX_BUFFER_FULL_FLAG] !== 1'b1);
            chk(v[5:3], 3'h0);
            rdc(OFS_RXD, exp_rx(d[15:8], modes[i]));
        end
        d = xs();
        wr(OFS_TXD, d[7:0]);
        do rd(OFS_STS); while (v[STS_TX_BUFFER_EMPTY_FLAG] !== 1'b1);
        wr(OFS_TXD, d[15:8]);
        do rd(OFS_STS); while (v[STS_TEND] !== 1'b1);
        chk(v[6:5], 2'h3);
        rdc(OFS_RXD, exp_rx(d[7:0], 8'h01));
        wr(OFS_STS, 32'h20);
        rdc(OFS_STS, 32'h84);
        wr(OFS_CTL, 32'h31);
        wr(OFS_FMT, 32'h80);
        wr(OFS_TXD, d[23:16]);
        do rd(OFS_STS); while (v[STS_TEND] !== 1'b1);
        repeat (2) @(posedge ref_clk_i);
        chk({sck_oe_o, sck_o}, 2'h3);
        chk({irq_tx_end_o, irq_tx_empty_o, irq_rx_full_o,
             irq_rx_err_o}, 4'hc);
        give_verdict();
    end
endmodule
`default_nettype wire
